/* core/pmc_pkg.sv */
package pmc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int PMC_NUM_CELLS  = 20;
    localparam int PMC_NUM_PINS   = 8;
    localparam int PMC_NUM_IN     = 36;
    localparam int PMC_NUM_GCLK   = 8;
    localparam int PMC_NUM_TERMS  = 8;
    localparam int PMC_ADDR_W     = 12;
    localparam int PMC_CFG_W      = 14;

    ////////////////////////////////////////////////////////////////////////////
    // Register map and field positions
    localparam logic [11:0] PMC_CLK_SEL    = 12'h000;
    localparam logic [11:0] PMC_TERM_KIND  = 12'h004;
    localparam logic [11:0] PMC_CELL_STATE = 12'h008;
    localparam logic [11:0] PMC_STATUS     = 12'h00C;
    localparam logic [11:0] PMC_TERM_BASE  = 12'h040;
    localparam logic [11:0] PMC_TERM_END   = 12'h080;
    localparam logic [11:0] PMC_CELL_BASE  = 12'h100;
    localparam int          PMC_TERM_SHIFT = 3;
    localparam int          PMC_CELL_SHIFT = 5;
    localparam int          PMC_GSEL_B_LSB = 3;
    localparam int          PMC_ST_TS_BIT  = 0;
    localparam int          PMC_ST_RST_BIT = 1;
    localparam int          PMC_ST_CT_LSB  = 8;
    localparam logic [2:0]  PMC_W_CFG      = 3'h0;
    localparam logic [2:0]  PMC_W_PAL_LO   = 3'h1;
    localparam logic [2:0]  PMC_W_PAL_HI   = 3'h2;
    localparam logic [2:0]  PMC_W_PLA_LO   = 3'h3;
    localparam logic [2:0]  PMC_W_PLA_HI   = 3'h4;
    localparam logic [5:0]  PMC_GSEL_RST   = 6'h08;

    ////////////////////////////////////////////////////////////////////////////
    // Control term indices and cell option encodings
    localparam int         PMC_CT_PR_A = 0;
    localparam int         PMC_CT_OE_A = 2;
    localparam int         PMC_CT_CK_A = 6;
    localparam int         PMC_CT_CK_B = 7;
    localparam logic [2:0] PMC_OE_OFF  = 3'h0;
    localparam logic [2:0] PMC_OE_ON   = 3'h1;
    localparam logic [2:0] PMC_OE_A    = 3'h2;
    localparam logic [2:0] PMC_OE_B    = 3'h3;
    localparam logic [2:0] PMC_OE_C    = 3'h4;
    localparam logic [2:0] PMC_OE_D    = 3'h5;
    localparam logic [1:0] PMC_AS_RST  = 2'h1;
    localparam logic [1:0] PMC_AS_PRE  = 2'h2;
    localparam logic [1:0] PMC_CK_GA   = 2'h0;
    localparam logic [1:0] PMC_CK_GB   = 2'h1;
    localparam logic [1:0] PMC_CK_TA   = 2'h2;
    localparam logic [1:0] PMC_CK_TB   = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {PMC_COMB, PMC_DFF, PMC_TFF} pmc_mode_t;

    typedef struct packed {
        logic       pin_input;
        logic       invert;
        logic       use_xor;
        logic [2:0] oe_sel;
        logic       async_term;
        logic [1:0] async_sel;
        logic       fall_edge;
        logic [1:0] clk_sel;
        pmc_mode_t  mode;
    } pmc_cell_cfg_t;

    typedef enum logic [3:0] {
        PMC_K_NONE, PMC_K_CLK, PMC_K_KIND, PMC_K_RO, PMC_K_TLO, PMC_K_THI,
        PMC_K_CFG, PMC_K_PAL_LO, PMC_K_PAL_HI, PMC_K_PLA_LO, PMC_K_PLA_HI
    } pmc_reg_kind_t;

endpackage : pmc_pkg

/* core/pmc_macrocell_block.sv */
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
module pmc_macrocell_block
    import pmc_pkg::*;
#(
    parameter int NUM_CELLS = PMC_NUM_CELLS,
    parameter int NUM_PINS  = PMC_NUM_PINS
) (
    // APB slave
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [PMC_ADDR_W-1:0] paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Global pins
    input  wire logic [PMC_NUM_GCLK-1:0] global_clock,
    input  wire logic                    global_reset_n,
    input  wire logic                    global_tristate,
    // Interconnect side
    input  wire logic [PMC_NUM_IN-1:0] local_interconnect,
    output logic      [NUM_CELLS-1:0]  cell_feedback,
    output logic      [NUM_PINS-1:0]   pin_feedback,
    // I/O pins
    input  wire logic [NUM_PINS-1:0]   pin_in,
    output logic      [NUM_PINS-1:0]   pin_out,
    output logic      [NUM_PINS-1:0]   pin_oe,
    output logic      [NUM_PINS-1:0]   pin_pulldown
);

    ////////////////////////////////////////////////////////////////////////////
    // Layout of the synchronised input vector
    localparam int OFF_LI  = PMC_NUM_GCLK;
    localparam int OFF_PIN = OFF_LI + PMC_NUM_IN;
    localparam int OFF_RST = OFF_PIN + NUM_PINS;
    localparam int OFF_TS  = OFF_RST + 1;
    localparam int EXT_W   = OFF_TS + 1;
    localparam int CIDX_W  = $clog2(NUM_CELLS);
    localparam logic [PMC_ADDR_W-1:0] CELL_END =
        PMC_ADDR_W'(int'(PMC_CELL_BASE) + (NUM_CELLS << PMC_CELL_SHIFT));

    typedef struct packed {
        logic [2:0][EXT_W-1:0]                   sync;
        logic [EXT_W-1:0]                        lvl;
        logic [1:0]                              ct_prev;
        logic [5:0]                              gsel;
        logic [PMC_NUM_TERMS-1:0]                term_sum;
        logic [PMC_NUM_TERMS-1:0][PMC_NUM_IN-1:0] ct_mask;
        pmc_cell_cfg_t [NUM_CELLS-1:0]           cfg;
        logic [NUM_CELLS-1:0][PMC_NUM_IN-1:0]    pal_mask;
        logic [NUM_CELLS-1:0][PMC_NUM_IN-1:0]    pla_mask;
        logic [NUM_CELLS-1:0]                    q;
        logic [31:0]                             prdata;
    } pmc_state_t;

    pmc_state_t                  st;
    pmc_state_t                  next_st;
    logic [EXT_W-1:0]            agree;
    logic [PMC_NUM_IN-1:0]       li;
    logic [PMC_NUM_GCLK-1:0]     g_rise;
    logic [PMC_NUM_GCLK-1:0]     g_fall;
    logic [PMC_NUM_TERMS-1:0]    ct_val;
    logic                        ct_rise_a;
    logic                        ct_rise_b;
    logic [NUM_CELLS-1:0]        cell_d;
    logic [NUM_CELLS-1:0]        cell_ev;
    logic [NUM_CELLS-1:0]        async_hit;
    logic [NUM_CELLS-1:0]        cell_oe;
    logic [NUM_CELLS-1:0]        next_q;
    logic [31:0]                 rd_val;
    pmc_reg_kind_t               kind;
    logic [CIDX_W-1:0]           cidx;
    logic [2:0]                  tidx;
    logic [PMC_ADDR_W-1:0]       cell_off;

    // Product term is empty when unprogrammed; sum term is an OR of picks
    function automatic logic pmc_term(input logic [PMC_NUM_IN-1:0] m,
                                      input logic [PMC_NUM_IN-1:0] v,
                                      input logic                  sum);
        pmc_term = sum ? |(m & v) : (|m && &(v | ~m));
    endfunction : pmc_term

    ////////////////////////////////////////////////////////////////////////////
    // Input filtering: a change counts when stages two and three agree
    assign agree  = st.sync[1] ~^ st.sync[2];
    assign li     = st.lvl[OFF_LI +: PMC_NUM_IN];
    assign g_rise = agree[PMC_NUM_GCLK-1:0] & st.sync[2][PMC_NUM_GCLK-1:0]
                    & ~st.lvl[PMC_NUM_GCLK-1:0];
    assign g_fall = agree[PMC_NUM_GCLK-1:0] & ~st.sync[2][PMC_NUM_GCLK-1:0]
                    & st.lvl[PMC_NUM_GCLK-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Control terms, each a sum or a product of the 36 inputs
    for (genvar t = 0; t < PMC_NUM_TERMS; t++) begin : g_term
        assign ct_val[t] = pmc_term(st.ct_mask[t], li, st.term_sum[t]);
    end
    assign ct_rise_a = ct_val[PMC_CT_CK_A] & ~st.ct_prev[0];
    assign ct_rise_b = ct_val[PMC_CT_CK_B] & ~st.ct_prev[1];

    ////////////////////////////////////////////////////////////////////////////
    // Per-cell logic, clocking, async control and output buffer
    for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
        pmc_cell_cfg_t cf;
        logic          pal;
        logic          pla;
        assign cf  = st.cfg[c];
        assign pal = pmc_term(st.pal_mask[c], li, 1'b0);
        assign pla = pmc_term(st.pla_mask[c], li, 1'b0);
        assign cell_d[c] = cf.invert ^ (cf.use_xor ? (pal ^ pla) : (pal | pla));
        assign async_hit[c] = ((cf.async_sel == PMC_AS_RST) || (cf.async_sel == PMC_AS_PRE))
                              && ct_val[PMC_CT_PR_A + int'(cf.async_term)];

        // Clock source choice and edge polarity
        always_comb begin
            case (cf.clk_sel)
                PMC_CK_GA: cell_ev[c] = cf.fall_edge ? g_fall[st.gsel[2:0]]
                                                     : g_rise[st.gsel[2:0]];
                PMC_CK_GB: cell_ev[c] = cf.fall_edge ? g_fall[st.gsel[5:3]]
                                                     : g_rise[st.gsel[5:3]];
                PMC_CK_TA: cell_ev[c] = ct_rise_a;
                default:   cell_ev[c] = ct_rise_b;
            endcase
        end

        // Storage update; global reset beats everything
        always_comb begin
            if (!st.lvl[OFF_RST]) begin
                next_q[c] = 1'b0;
            end else if (async_hit[c]) begin
                next_q[c] = (cf.async_sel == PMC_AS_PRE);
            end else if (cf.mode == PMC_DFF && cell_ev[c]) begin
                next_q[c] = cell_d[c];
            end else if (cf.mode == PMC_TFF && cell_ev[c]) begin
                next_q[c] = st.q[c] ^ cell_d[c];
            end else if (cf.mode == PMC_DFF || cf.mode == PMC_TFF) begin
                next_q[c] = st.q[c];
            end else begin
                next_q[c] = 1'b0;
            end
        end

        // Combinatorial cells bypass storage; feedback before the buffer
        assign cell_feedback[c] = (cf.mode == PMC_DFF || cf.mode == PMC_TFF)
                                  ? st.q[c] : cell_d[c];

        // Output enable choice
        always_comb begin
            case (cf.oe_sel)
                PMC_OE_ON: cell_oe[c] = 1'b1;
                PMC_OE_A:  cell_oe[c] = ct_val[PMC_CT_OE_A];
                PMC_OE_B:  cell_oe[c] = ct_val[PMC_CT_OE_A + 1];
                PMC_OE_C:  cell_oe[c] = ct_val[PMC_CT_OE_A + 2];
                PMC_OE_D:  cell_oe[c] = ct_val[PMC_CT_OE_A + 3];
                default:   cell_oe[c] = 1'b0;
            endcase
        end

        if (c < NUM_PINS) begin : g_pin
            assign pin_out[c]      = cell_feedback[c];
            assign pin_oe[c]       = cell_oe[c] & ~st.lvl[OFF_TS];
            assign pin_feedback[c] = st.lvl[OFF_PIN + c];
            assign pin_pulldown[c] = (cf.oe_sel == PMC_OE_OFF) & ~cf.pin_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB address decode
    assign cell_off = paddr - PMC_CELL_BASE;
    always_comb begin
        rd_val = '0;
        kind   = PMC_K_NONE;
        cidx   = CIDX_W'(cell_off >> PMC_CELL_SHIFT);
        tidx   = paddr[PMC_TERM_SHIFT +: 3];
        if (paddr[1:0] != 2'h0) begin
            kind = PMC_K_NONE;
        end else if (paddr == PMC_CLK_SEL) begin
            kind        = PMC_K_CLK;
            rd_val[5:0] = st.gsel;
        end else if (paddr == PMC_TERM_KIND) begin
            kind                      = PMC_K_KIND;
            rd_val[PMC_NUM_TERMS-1:0] = st.term_sum;
        end else if (paddr == PMC_CELL_STATE) begin
            kind                  = PMC_K_RO;
            rd_val[NUM_CELLS-1:0] = st.q;
        end else if (paddr == PMC_STATUS) begin
            kind                                  = PMC_K_RO;
            rd_val[PMC_ST_TS_BIT]                 = st.lvl[OFF_TS];
            rd_val[PMC_ST_RST_BIT]                = ~st.lvl[OFF_RST];
            rd_val[PMC_ST_CT_LSB +: PMC_NUM_TERMS] = ct_val;
        end else if (paddr >= PMC_TERM_BASE && paddr < PMC_TERM_END) begin
            kind   = paddr[2] ? PMC_K_THI : PMC_K_TLO;
            rd_val = paddr[2] ? 32'(st.ct_mask[tidx][PMC_NUM_IN-1:32])
                              : st.ct_mask[tidx][31:0];
        end else if (paddr >= PMC_CELL_BASE && paddr < CELL_END) begin
            case (paddr[4:2])
                PMC_W_CFG: begin
                    kind   = PMC_K_CFG;
                    rd_val = 32'(st.cfg[cidx]);
                end
                PMC_W_PAL_LO: begin
                    kind   = PMC_K_PAL_LO;
                    rd_val = st.pal_mask[cidx][31:0];
                end
                PMC_W_PAL_HI: begin
                    kind   = PMC_K_PAL_HI;
                    rd_val = 32'(st.pal_mask[cidx][PMC_NUM_IN-1:32]);
                end
                PMC_W_PLA_LO: begin
                    kind   = PMC_K_PLA_LO;
                    rd_val = st.pla_mask[cidx][31:0];
                end
                PMC_W_PLA_HI: begin
                    kind   = PMC_K_PLA_HI;
                    rd_val = 32'(st.pla_mask[cidx][PMC_NUM_IN-1:32]);
                end
                default: kind = PMC_K_NONE;
            endcase
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & (kind == PMC_K_NONE);
    assign prdata  = st.prdata;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st         = st;
        next_st.sync[0] = {global_tristate, global_reset_n, pin_in,
                           local_interconnect, global_clock};
        next_st.sync[1] = st.sync[0];
        next_st.sync[2] = st.sync[1];
        next_st.lvl     = (agree & st.sync[2]) | (~agree & st.lvl);
        next_st.ct_prev = {ct_val[PMC_CT_CK_B], ct_val[PMC_CT_CK_A]};
        next_st.q       = next_q;
        if (psel && !penable) begin
            next_st.prdata = rd_val;
        end
        if (psel && penable && pwrite) begin
            case (kind)
                PMC_K_CLK:  next_st.gsel     = pwdata[5:0];
                PMC_K_KIND: next_st.term_sum = pwdata[PMC_NUM_TERMS-1:0];
                PMC_K_TLO:  next_st.ct_mask[tidx][31:0] = pwdata;
                PMC_K_THI:  next_st.ct_mask[tidx][PMC_NUM_IN-1:32] = pwdata[3:0];
                PMC_K_CFG:  next_st.cfg[cidx] = pmc_cell_cfg_t'(pwdata[PMC_CFG_W-1:0]);
                PMC_K_PAL_LO: next_st.pal_mask[cidx][31:0] = pwdata;
                PMC_K_PAL_HI: next_st.pal_mask[cidx][PMC_NUM_IN-1:32] = pwdata[3:0];
                PMC_K_PLA_LO: next_st.pla_mask[cidx][31:0] = pwdata;
                PMC_K_PLA_HI: next_st.pla_mask[cidx][PMC_NUM_IN-1:32] = pwdata[3:0];
                default: ;
            endcase
        end
    end

    // State register; storage comes up cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= '0;
            st.gsel <= PMC_GSEL_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on cell 0, plus global reset on all cells and tristate on all pins
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_global_reset_clears: assert property (!st.lvl[OFF_RST] |=> st.q == '0)
        else $error("global reset did not clear storage");
    a_reset_beats_async: assert property (
        (!st.lvl[OFF_RST] && async_hit[0]) |=> !st.q[0])
        else $error("async term overrode global reset");
    a_tristate_all_off: assert property (st.lvl[OFF_TS] |-> pin_oe == '0)
        else $error("output enabled during global tristate");
    a_oe_always_on: assert property (
        (st.cfg[0].oe_sel == PMC_OE_ON && !st.lvl[OFF_TS]) |-> pin_oe[0])
        else $error("always-on buffer not enabled");
    a_oe_term_a: assert property (
        (st.cfg[0].oe_sel == PMC_OE_A && !st.lvl[OFF_TS])
        |-> pin_oe[0] == ct_val[PMC_CT_OE_A])
        else $error("enable term not followed");
    a_d_capture: assert property (
        (st.lvl[OFF_RST] && st.cfg[0].mode == PMC_DFF && cell_ev[0] && !async_hit[0])
        |=> st.q[0] == $past(cell_d[0]))
        else $error("D capture wrong");
    a_t_toggle: assert property (
        (st.lvl[OFF_RST] && st.cfg[0].mode == PMC_TFF && cell_ev[0] && !async_hit[0])
        |=> st.q[0] == ($past(st.q[0]) ^ $past(cell_d[0])))
        else $error("T toggle wrong");
    a_hold_no_edge: assert property (
        (st.lvl[OFF_RST] && (st.cfg[0].mode == PMC_DFF || st.cfg[0].mode == PMC_TFF)
         && !cell_ev[0] && !async_hit[0])
        |=> $stable(st.q[0]))
        else $error("storage changed without clock");
    a_async_preset: assert property (
        (st.lvl[OFF_RST] && async_hit[0] && st.cfg[0].async_sel == PMC_AS_PRE)
        |=> st.q[0])
        else $error("async preset failed");
    a_comb_path: assert property (
        st.cfg[0].mode == PMC_COMB |-> cell_feedback[0] == cell_d[0])
        else $error("combinatorial path not transparent");
    a_pulldown_unused: assert property (pin_pulldown[0] |-> !pin_oe[0])
        else $error("pull-down on a driven pin");

    c_d_capture: cover property (st.cfg[0].mode == PMC_DFF && cell_ev[0] ##1 st.q[0]);
    c_t_toggle: cover property (st.cfg[0].mode == PMC_TFF && cell_ev[0] && cell_d[0]);
    c_preset: cover property (async_hit[0] && st.cfg[0].async_sel == PMC_AS_PRE);
    c_tristate: cover property (st.lvl[OFF_TS] && cell_oe[0]);

endmodule : pmc_macrocell_block

/* test/pmc_pin_model.sv */
`timescale 1ns/100ps
module pmc_pin_model
    import pmc_pkg::*;
(
    // Clock
    input  wire logic                    pclk,
    // Block pin side
    input  wire logic [PMC_NUM_PINS-1:0] pin_out,
    input  wire logic [PMC_NUM_PINS-1:0] pin_oe,
    input  wire logic [PMC_NUM_PINS-1:0] pin_pulldown,
    // Board driver commanded by the bench
    input  wire logic [PMC_NUM_PINS-1:0] ext_en,
    input  wire logic [PMC_NUM_PINS-1:0] ext_val,
    // Resolved pad level
    output logic      [PMC_NUM_PINS-1:0] pin_in
);
    logic [PMC_NUM_PINS-1:0] float_lvl = '0;
    ////////////////////////////////////////////////////////////////////////////
    // Undriven pads without pull-down wander every cycle, never a stale level
    always_ff @(posedge pclk) begin
        float_lvl <= ~float_lvl;
    end
    // Pad resolution: block driver, board driver, pull-down, floating
    always_comb begin
        for (int i = 0; i < PMC_NUM_PINS; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pulldown[i]) pin_in[i] = 1'b0;
            else pin_in[i] = float_lvl[i];
        end
    end
endmodule : pmc_pin_model

/* test/pmc_macrocell_block_bench.sv */
`timescale 1ns/100ps
module pmc_macrocell_block_bench
    import pmc_pkg::*;
    ;
    logic                     pclk = 1'b0, presetn = 1'b0;
    logic [PMC_ADDR_W-1:0]    paddr = '0;
    logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]              pwdata = '0, prdata, rd;
    logic                     pready, pslverr, err;
    logic [PMC_NUM_GCLK-1:0]  global_clock = '0;
    logic                     global_reset_n = 1'b1, global_tristate = 1'b0;
    logic [PMC_NUM_IN-1:0]    li = '0;
    logic [PMC_NUM_CELLS-1:0] cell_fb;
    logic [PMC_NUM_PINS-1:0]  pin_fb, pin_in, pin_out, pin_oe, pin_pd;
    logic [PMC_NUM_PINS-1:0]  ext_en = '0, ext_val = '0;
    int                       fails = 0, n_tests = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Block under test and its pads
    pmc_macrocell_block pmc_macrocell_block_inst (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_clock(global_clock),
        .global_reset_n(global_reset_n), .global_tristate(global_tristate),
        .local_interconnect(li), .cell_feedback(cell_fb), .pin_feedback(pin_fb),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldown(pin_pd));
    pmc_pin_model pmc_pin_model_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pulldown(pin_pd), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt
    // One APB transfer: setup, access held until pready sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        wt(2);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic setli(input logic [PMC_NUM_IN-1:0] v);
        @(posedge pclk);
        li <= v;
        wt(6);
    endtask : setli
    task automatic clkp(input int n, input logic v);
        @(posedge pclk);
        global_clock[n] <= v;
        wt(6);
    endtask : clkp
    function automatic logic [11:0] ca(input int c, input int off);
        return PMC_CELL_BASE + 12'(c * 32 + off);
    endfunction : ca
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wt(4);
        chk("oe_rst", pin_oe, 32'h00000000);
        chk("fb_rst", cell_fb, 32'h00000000);
        chk("pd_rst", pin_pd, 32'h000000FF);
        apb(1'b0, PMC_CLK_SEL, 32'h00000000);
        chk("clksel_rst", rd, 32'(PMC_GSEL_RST));
        apb(1'b0, 12'h090, 32'h00000000);
        chk("unmapped_err", err, 32'h00000001);
        apb(1'b0, 12'h002, 32'h00000000);
        chk("misaligned_err", err, 32'h00000001);
        // Pin cell 0 logic: OR/XOR, true/inverted
        wr(ca(0, 4), 32'h00000001);
        wr(ca(0, 12), 32'h00000002);
        setli(36'h3);
        for (int i = 0; i < 4; i++) begin
            wr(ca(0, 0), 32'h00000100 | (32'(i) << 11));
            wt(6);
            chk("comb", cell_fb[0], ((i == 0) || (i == 3)));
            chk("pin_out", pin_out[0], ((i == 0) || (i == 3)));
            chk("pin_fb", pin_fb[0], ((i == 0) || (i == 3)));
            chk("pd_used", pin_pd[0], 32'h00000000);
        end
        // Each enable term selects the buffer alone
        for (int k = 0; k < 4; k++) begin
            wr(PMC_TERM_BASE + 12'((2 + k) * 8), 32'h00000001 << (6 + k));
        end
        for (int k = 0; k < 4; k++) begin
            wr(ca(0, 0), 32'(k + 2) << 8);
            setli(36'h3 | (36'h40 << k));
            chk("oe_term_on", pin_oe[0], 32'h00000001);
            setli(36'h3 | (36'h3C0 & ~(36'h40 << k)));
            chk("oe_term_off", pin_oe[0], 32'h00000000);
        end
        wr(ca(0, 0), 32'h00000000);
        chk("oe_never", pin_oe[0], 32'h00000000);
        chk("pd_unused", pin_pd[0], 32'h00000001);
        wr(ca(0, 0), 32'h00000100);
        chk("oe_always", pin_oe[0], 32'h00000001);
        @(posedge pclk);
        global_tristate <= 1'b1;
        wt(6);
        chk("tristate", pin_oe, 32'h00000000);
        @(posedge pclk);
        global_tristate <= 1'b0;
        // Pin used as input
        wr(ca(0, 0), 32'h00002000);
        @(posedge pclk);
        ext_en[0] <= 1'b1;
        ext_val[0] <= 1'b1;
        wt(6);
        chk("in_oe", pin_oe[0], 32'h00000000);
        chk("in_pd", pin_pd[0], 32'h00000000);
        chk("in_fb", pin_fb[0], 32'h00000001);
        chk("in_cell", cell_fb[0], 32'h00000001);
        @(posedge pclk);
        ext_val[0] <= 1'b0;
        wt(6);
        chk("in_fb0", pin_fb[0], 32'h00000000);
        // Buried D cell 8 on global clocks, rising then falling
        wr(ca(8, 4), 32'h00000001);
        wr(ca(8, 0), 32'h00000001);
        wr(ca(0, 0), 32'h00002001);
        setli(36'h1);
        clkp(0, 1'b1);
        chk("dff", cell_fb[8], 32'h00000001);
        chk("dff_pin", cell_fb[0], 32'h00000001);
        clkp(0, 1'b0);
        setli(36'h0);
        wr(PMC_CLK_SEL, 32'h0000000D);
        wr(ca(8, 0), 32'h00000011);
        clkp(5, 1'b1);
        chk("dff_fall_hold", cell_fb[8], 32'h00000001);
        clkp(5, 1'b0);
        chk("dff_fall", cell_fb[8], 32'h00000000);
        // T cells 9 and 0 on the second global clock
        wr(ca(9, 4), 32'h00000001);
        wr(ca(9, 0), 32'h00000006);
        wr(ca(0, 0), 32'h00002006);
        setli(36'h1);
        for (int n = 0; n < 3; n++) begin
            clkp(1, 1'b1);
            chk("tff", cell_fb[9], (n % 2 == 0));
            chk("tff_pin", cell_fb[0], (n % 2 == 0));
            clkp(1, 1'b0);
        end
        setli(36'h0);
        clkp(1, 1'b1);
        chk("tff_hold", cell_fb[9], 32'h00000001);
        clkp(1, 1'b0);
        // Async preset on cells 8 and 0, reset on cell 8, then global reset
        wr(PMC_TERM_BASE, 32'h00000004);
        wr(ca(8, 0), 32'h00000041);
        wr(ca(0, 0), 32'h00002041);
        setli(36'h4);
        chk("preset", cell_fb[8], 32'h00000001);
        wr(ca(8, 0), 32'h00000021);
        chk("reset", cell_fb[8], 32'h00000000);
        wr(ca(8, 0), 32'h00000041);
        setli(36'h0);
        chk("preset_held", cell_fb[8], 32'h00000001);
        // Global reset must win over an active preset term
        setli(36'h4);
        @(posedge pclk);
        global_reset_n <= 1'b0;
        wt(6);
        chk("greset", cell_fb[8], 32'h00000000);
        chk("greset_pin", cell_fb[0], 32'h00000000);
        apb(1'b0, PMC_STATUS, 32'h00000000);
        chk("status", rd, 32'h00000102);
        apb(1'b0, PMC_CELL_STATE, 32'h00000000);
        chk("state_greset", rd, 32'h00000000);
        @(posedge pclk);
        global_reset_n <= 1'b1;
        wt(6);
        // Cell 10 clocked by clock term a: product, then sum
        wr(PMC_TERM_BASE + 12'h030, 32'h00000010);
        wr(ca(10, 4), 32'h00000001);
        wr(ca(10, 0), 32'h00000009);
        setli(36'h1);
        setli(36'h11);
        chk("ct_prod", cell_fb[10], 32'h00000001);
        wr(PMC_TERM_KIND, 32'h00000040);
        wr(PMC_TERM_BASE + 12'h030, 32'h00000030);
        setli(36'h0);
        setli(36'h20);
        chk("ct_sum", cell_fb[10], 32'h00000000);
        apb(1'b0, PMC_TERM_KIND, 32'h00000000);
        chk("term_kind", rd, 32'h00000040);
        tally_and_finish();
    end
endmodule : pmc_macrocell_block_bench
